// *** timer_wave_regs.vh ***
// register offsets, field positions, reset values and count limits
// for the two-timer waveform and compare-output block
// assumes an 8-bit register port with a 5-bit address
`ifndef TIMER_WAVE_REGS_VH
`define TIMER_WAVE_REGS_VH

// ----------------------------------------------------------------
// address layout: bit 4 picks the timer, bits 3:0 the register
// ----------------------------------------------------------------
`define TSEL_BIT       4
`define OFS_CTRL_FIRST 4'h0
`define OFS_CTRL_SECND 4'h1
`define OFS_CMPA_LO    4'h2
`define OFS_CMPA_HI    4'h3
`define OFS_CMPB_LO    4'h4
`define OFS_CMPB_HI    4'h5
`define OFS_CMPC_LO    4'h6
`define OFS_CMPC_HI    4'h7
`define OFS_CAP_LO     4'h8
`define OFS_CAP_HI     4'h9
`define OFS_CNT_LO     4'ha
`define OFS_CNT_HI     4'hb
`define OFS_STATUS     4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define F_OMODE_A      7:6
`define F_OMODE_B      5:4
`define F_OMODE_C      3:2
`define F_WMODE_LOW    1:0
`define F_WMODE_HIGH   4:3
`define F_OVF          0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CTRL       8'h00
`define RST_WORD       16'h0000

// ----------------------------------------------------------------
// counter limits
// ----------------------------------------------------------------
`define CNT_BOTTOM     16'h0000
`define CNT_MAX        16'hffff
`define TOP_8BIT       16'h00ff
`define TOP_9BIT       16'h01ff
`define TOP_10BIT      16'h03ff

// ----------------------------------------------------------------
// output-mode encodings
// ----------------------------------------------------------------
`define OM_OFF         2'h0
`define OM_TOGGLE      2'h1
`define OM_CLEAR       2'h2
`define OM_SET         2'h3

// ----------------------------------------------------------------
// waveform modes
// ----------------------------------------------------------------
`define WM_NORMAL      4'h0
`define WM_PC8         4'h1
`define WM_PC9         4'h2
`define WM_PC10        4'h3
`define WM_CTC_CMPA    4'h4
`define WM_FAST8       4'h5
`define WM_FAST9       4'h6
`define WM_FAST10      4'h7
`define WM_PFC_CAP     4'h8
`define WM_PFC_CMPA    4'h9
`define WM_PC_CAP      4'ha
`define WM_PC_CMPA     4'hb
`define WM_CTC_CAP     4'hc
`define WM_RESERVED    4'hd
`define WM_FAST_CAP    4'he
`define WM_FAST_CMPA   4'hf

`endif

// *** timer_wave.v ***
// two 16-bit timers: count sequence, compare reload, overflow flag
// and compare-output waveform with pin takeover for channels a/b/c
// assumes timer_tick is a one-cycle prescaled enable on ref_clk and
// that the port logic muxes each pin by its takeover output
//
// Notes on behaviour
// - output-mode fields: channel a bits 7:6, b bits 5:4, c bits 3:2
// - a 1x output-mode field, or 01 where toggle is live, hands the pin to the compare output
// - non-pwm: 00 off, 01 toggle, 10 low, 11 high on match
// - fast pwm: 10 clears on match, sets at top; 11 the reverse
// - fast pwm 01 toggles channel a only in mode 15, else disconnected
// - fast pwm with compare equal top: match ignored, top action kept
// - dual slope: 10 clears on up match, sets on down; 11 reverse
// - dual slope 01 toggles channel a only in mode 9
// - 4-bit mode: low bits from first control, high from second; 13 reserved
// - mode 0 counts to 0xffff, immediate compare load, overflow at max
// - modes 1-3 phase correct, fixed tops, reload at top, flag at bottom
// - modes 5-7,14,15 fast pwm, reload and flag at top
// - modes 4 and 12 clear on match, immediate load, flag at max
// - modes 8 and 9 phase-frequency correct, reload and flag at bottom
// - modes 10 and 11 phase correct, reload at top, flag at bottom
// - high mode bits sit at bits 4:3 of the second control register
// - dual slope counts from 0x0000 up to top and back down
// - dual slope compare at bottom holds the match level, at or above top its inverse
`include "timer_wave_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module timer_wave (
  input  wire       ref_clk,
  input  wire       nrst,
  input  wire       clk_en,
  input  wire       timer_tick,
  input  wire [4:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output wire [7:0] rdata,
  output wire [1:0] compare_pin_a,
  output wire [1:0] compare_pin_b,
  output wire [1:0] compare_pin_c,
  output wire [1:0] takeover_a,
  output wire [1:0] takeover_b,
  output wire [1:0] takeover_c
);

  // ----------------------------------------------------------------
  // mode classification and top selection
  // ----------------------------------------------------------------
  function is_fast;
    input [3:0] md;
    begin
      case (md)
        `WM_FAST8, `WM_FAST9, `WM_FAST10,
        `WM_FAST_CAP, `WM_FAST_CMPA: is_fast = 1'b1;
        default: is_fast = 1'b0;
      endcase
    end
  endfunction

  function is_dual;
    input [3:0] md;
    begin
      case (md)
        `WM_PC8, `WM_PC9, `WM_PC10, `WM_PFC_CAP,
        `WM_PFC_CMPA, `WM_PC_CAP, `WM_PC_CMPA: is_dual = 1'b1;
        default: is_dual = 1'b0;
      endcase
    end
  endfunction

  function [15:0] top_of;
    input [3:0]  md;
    input [15:0] cmpa;
    input [15:0] cap;
    begin
      case (md)
        `WM_PC8, `WM_FAST8:   top_of = `TOP_8BIT;
        `WM_PC9, `WM_FAST9:   top_of = `TOP_9BIT;
        `WM_PC10, `WM_FAST10: top_of = `TOP_10BIT;
        `WM_CTC_CMPA, `WM_PFC_CMPA,
        `WM_PC_CMPA, `WM_FAST_CMPA: top_of = cmpa;
        `WM_PFC_CAP, `WM_PC_CAP,
        `WM_CTC_CAP, `WM_FAST_CAP: top_of = cap;
        default: top_of = `CNT_MAX;
      endcase
    end
  endfunction

  // toggle encoding is live on every channel in non-pwm modes, on channel a only in a few pwm modes
  function tog_ok;
    input [3:0] md;
    input [1:0] ch;
    begin
      if (is_fast(md))
        tog_ok = (ch == 2'd0) && (md == `WM_FAST_CMPA);
      else if (is_dual(md))
        tog_ok = (ch == 2'd0) &&
                 (md == `WM_PFC_CMPA || md == `WM_FAST_CAP);
      else
        tog_ok = 1'b1;
    end
  endfunction

  // channel field out of the first control register
  function [1:0] omode;
    input [7:0] c1;
    input [1:0] ch;
    begin
      case (ch)
        2'd0:    omode = c1[`F_OMODE_A];
        2'd1:    omode = c1[`F_OMODE_B];
        default: omode = c1[`F_OMODE_C];
      endcase
    end
  endfunction

  // upper field bit set: a clear/set encoding, which always owns the pin
  function level_mode;
    input [7:0] c1;
    input [1:0] ch;
    reg   [1:0] f;
    begin
      f          = omode(c1, ch);
      level_mode = f[1];
    end
  endfunction

  // lower field bit: level a clear/set encoding writes on an up-count match
  function match_level;
    input [7:0] c1;
    input [1:0] ch;
    reg   [1:0] f;
    begin
      f           = omode(c1, ch);
      match_level = f[0];
    end
  endfunction

  // ----------------------------------------------------------------
  // per-timer logic
  // ----------------------------------------------------------------
  wire [7:0] rd_val [0:1];
  reg  [7:0] rdata_reg;

  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : tmr
      localparam [0:0] TSEL = (t == 1) ? 1'b1 : 1'b0;

      reg  [7:0]  ctrl_first_reg;
      reg  [7:0]  ctrl_second_reg;
      reg  [15:0] buf_reg [0:2];
      reg  [15:0] act_reg [0:2];
      reg  [15:0] cap_reg;
      reg  [15:0] cnt_reg;
      reg  [15:0] cnt_next;
      reg         down_reg;
      reg         down_next;
      reg         ovf_reg;
      reg  [2:0]  pin_reg;
      reg  [2:0]  take_reg;
      reg  [7:0]  rv;
      integer     i;

      wire        hit = (addr[`TSEL_BIT] == TSEL);
      wire        we  = wr_stb & hit;
      wire [3:0]  wm  = {ctrl_second_reg[`F_WMODE_HIGH],
                         ctrl_first_reg[`F_WMODE_LOW]};
      wire        fast   = is_fast(wm);
      wire        dual   = is_dual(wm);
      wire        nonpwm = ~fast & ~dual;
      wire        pfc    = (wm == `WM_PFC_CAP) | (wm == `WM_PFC_CMPA);
      wire        clear_on_match_mode    = (wm == `WM_CTC_CMPA) | (wm == `WM_CTC_CAP);
      wire [15:0] top    = top_of(wm, act_reg[0], cap_reg);
      wire        at_top = (cnt_reg == top);
      wire        at_bot = (cnt_reg == `CNT_BOTTOM);

      // reload point: top for fast pwm and phase correct, bottom for
      // phase-frequency correct
      wire reload = (fast & at_top) |
                    (dual & ~pfc & at_top) |
                    (dual & pfc & at_bot);

      wire ovf_set = timer_tick &
                     ((nonpwm & (cnt_reg == `CNT_MAX)) |
                      (fast & at_top) |
                      (dual & at_bot));
      wire ovf_clr = we & (addr[3:0] == `OFS_STATUS) & wdata[`F_OVF];

      // ------------------------------------------------------------
      // count sequence
      // ------------------------------------------------------------
      always @* begin
        cnt_next  = cnt_reg + 16'h0001;
        down_next = 1'b0;
        if (dual) begin
          down_next = down_reg;
          if (!down_reg && at_top) begin
            down_next = 1'b1;
            cnt_next  = cnt_reg - 16'h0001;
          end else if (down_reg && at_bot) begin
            down_next = 1'b0;
          end else if (down_reg) begin
            cnt_next  = cnt_reg - 16'h0001;
          end
        end else if ((fast | clear_on_match_mode) && at_top) begin
          cnt_next = `CNT_BOTTOM;
        end
      end

      // ------------------------------------------------------------
      // registers, counter, compare and outputs
      // ------------------------------------------------------------
      always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          ctrl_first_reg  <= `RST_CTRL;
          ctrl_second_reg <= `RST_CTRL;
          cap_reg         <= `RST_WORD;
          cnt_reg         <= `RST_WORD;
          down_reg        <= 1'b0;
          ovf_reg         <= 1'b0;
          pin_reg         <= 3'h0;
          take_reg        <= 3'h0;
          for (i = 0; i < 3; i = i + 1) begin
            buf_reg[i] <= `RST_WORD;
            act_reg[i] <= `RST_WORD;
          end
        end else if (clk_en) begin
          if (we) begin
            case (addr[3:0])
              `OFS_CTRL_FIRST: ctrl_first_reg  <= wdata;
              `OFS_CTRL_SECND: ctrl_second_reg <= wdata;
              `OFS_CMPA_LO:    buf_reg[0][7:0]  <= wdata;
              `OFS_CMPA_HI:    buf_reg[0][15:8] <= wdata;
              `OFS_CMPB_LO:    buf_reg[1][7:0]  <= wdata;
              `OFS_CMPB_HI:    buf_reg[1][15:8] <= wdata;
              `OFS_CMPC_LO:    buf_reg[2][7:0]  <= wdata;
              `OFS_CMPC_HI:    buf_reg[2][15:8] <= wdata;
              `OFS_CAP_LO:     cap_reg[7:0]     <= wdata;
              `OFS_CAP_HI:     cap_reg[15:8]    <= wdata;
              default: ;
            endcase
          end
          // set beats a clear landing in the same cycle
          if (ovf_set)
            ovf_reg <= 1'b1;
          else if (ovf_clr)
            ovf_reg <= 1'b0;
          for (i = 0; i < 3; i = i + 1) begin
            take_reg[i] <= level_mode(ctrl_first_reg, i[1:0]) ||
                           (omode(ctrl_first_reg, i[1:0]) == `OM_TOGGLE &&
                            tog_ok(wm, i[1:0]));
            if (nonpwm)
              act_reg[i] <= buf_reg[i];
            else if (timer_tick && reload)
              act_reg[i] <= buf_reg[i];
          end
          if (timer_tick) begin
            cnt_reg  <= cnt_next;
            down_reg <= down_next;
            for (i = 0; i < 3; i = i + 1) begin
              if (nonpwm) begin
                if (cnt_reg == act_reg[i]) begin
                  case (omode(ctrl_first_reg, i[1:0]))
                    `OM_TOGGLE: pin_reg[i] <= ~pin_reg[i];
                    `OM_CLEAR:  pin_reg[i] <= 1'b0;
                    `OM_SET:    pin_reg[i] <= 1'b1;
                    default: ;
                  endcase
                end
              end else if (level_mode(ctrl_first_reg, i[1:0])) begin
                if (fast) begin
                  // top action takes precedence over a match at top
                  if (at_top)
                    pin_reg[i] <= ~match_level(ctrl_first_reg, i[1:0]);
                  else if (cnt_reg == act_reg[i])
                    pin_reg[i] <= match_level(ctrl_first_reg, i[1:0]);
                end else if (act_reg[i] == `CNT_BOTTOM) begin
                  pin_reg[i] <= match_level(ctrl_first_reg, i[1:0]);
                end else if (act_reg[i] >= top) begin
                  pin_reg[i] <= ~match_level(ctrl_first_reg, i[1:0]);
                end else if (cnt_reg == act_reg[i]) begin
                  pin_reg[i] <= match_level(ctrl_first_reg, i[1:0]) ^ down_reg;
                end
              end else if (omode(ctrl_first_reg, i[1:0]) == `OM_TOGGLE &&
                           tog_ok(wm, i[1:0]) &&
                           cnt_reg == act_reg[i]) begin
                pin_reg[i] <= ~pin_reg[i];
              end
            end
          end
        end
      end

      // ------------------------------------------------------------
      // read view
      // ------------------------------------------------------------
      always @* begin
        rv = 8'h00;
        case (addr[3:0])
          `OFS_CTRL_FIRST: rv = ctrl_first_reg;
          `OFS_CTRL_SECND: rv = ctrl_second_reg;
          `OFS_CMPA_LO:    rv = buf_reg[0][7:0];
          `OFS_CMPA_HI:    rv = buf_reg[0][15:8];
          `OFS_CMPB_LO:    rv = buf_reg[1][7:0];
          `OFS_CMPB_HI:    rv = buf_reg[1][15:8];
          `OFS_CMPC_LO:    rv = buf_reg[2][7:0];
          `OFS_CMPC_HI:    rv = buf_reg[2][15:8];
          `OFS_CAP_LO:     rv = cap_reg[7:0];
          `OFS_CAP_HI:     rv = cap_reg[15:8];
          `OFS_CNT_LO:     rv = cnt_reg[7:0];
          `OFS_CNT_HI:     rv = cnt_reg[15:8];
          `OFS_STATUS:     rv = {7'h00, ovf_reg};
          default:         rv = 8'h00;
        endcase
      end

      assign rd_val[t]        = rv;
      assign compare_pin_a[t] = pin_reg[0];
      assign compare_pin_b[t] = pin_reg[1];
      assign compare_pin_c[t] = pin_reg[2];
      assign takeover_a[t]    = take_reg[0];
      assign takeover_b[t]    = take_reg[1];
      assign takeover_c[t]    = take_reg[2];
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data: valid only in the cycle after the read strobe
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      if (rd_stb)
        rdata_reg <= rd_val[addr[`TSEL_BIT]];
      else
        rdata_reg <= 8'h00;
    end
  end

  assign rdata = rdata_reg;

endmodule // timer_wave

`default_nettype wire

// *** timer_wave_monitor.sv ***
// concurrent checks on the ports of the two-timer waveform block
// assumes a single ref_clk domain with asynchronous active-low nrst
`timescale 1ns/10ps
`default_nettype none

module timer_wave_monitor (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic       timer_tick,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic [1:0] compare_pin_a,
  input wire logic [1:0] compare_pin_b,
  input wire logic [1:0] compare_pin_c,
  input wire logic [1:0] takeover_a,
  input wire logic [1:0] takeover_b,
  input wire logic [1:0] takeover_c
);
  // ----------------------------------------------------------------
  // helper flags
  // ----------------------------------------------------------------
  logic rd_q;
  logic en_q;
  logic tick_q;
  logic wr_q;
  logic wr2_q;
  // the write flags cover both control offsets and only move on enabled cycles
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= 1'b0;
      en_q <= 1'b0;
      tick_q <= 1'b0;
      wr_q <= 1'b0;
      wr2_q <= 1'b0;
    end else begin
      rd_q <= rd_stb & clk_en;
      en_q <= clk_en;
      tick_q <= clk_en & timer_tick;
      wr_q <= clk_en ? (wr_stb & (addr[3:1] == 3'h0)) : wr_q;
      wr2_q <= clk_en ? wr_q : wr2_q;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_takeover_a_t1: assert property ((wr_stb && clk_en && addr == 5'h00) ##1
    clk_en |=> takeover_a[0] == |$past(wdata[7:6], 2) || $past(wdata[7:6], 2) == 2'h1)
    else $error("takeover a of timer1 wrong");
  a_takeover_c_t3: assert property ((wr_stb && clk_en && addr == 5'h10) ##1
    clk_en |=> takeover_c[1] == |$past(wdata[3:2], 2) || $past(wdata[3:2], 2) == 2'h1)
    else $error("takeover c of timer3 wrong");
  a_ctrl_readback: assert property ((wr_stb && clk_en && addr == 5'h10) ##1
    (rd_stb && clk_en && addr == 5'h10) |=> rdata == $past(wdata, 2))
    else $error("control readback wrong");
  a_read_idle: assert property (en_q && !rd_q |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (rd_stb && clk_en && addr[3:0] >= 4'hd |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_bits: assert property (rd_stb && clk_en && addr[3:0] == 4'hc |=> rdata[7:1] == 7'h00)
    else $error("status upper bits not zero");
  a_pins_on_tick: assert property (!tick_q |-> $stable(compare_pin_a) &&
    $stable(compare_pin_b) && $stable(compare_pin_c)) else $error("pin moved without tick");
  a_takeover_cause: assert property ($changed(takeover_a) || $changed(takeover_b) ||
    $changed(takeover_c) |-> wr2_q) else $error("takeover moved without write");
endmodule // timer_wave_monitor

bind timer_wave timer_wave_monitor mon (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
  .timer_tick(timer_tick), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .compare_pin_a(compare_pin_a), .compare_pin_b(compare_pin_b),
  .compare_pin_c(compare_pin_c), .takeover_a(takeover_a), .takeover_b(takeover_b),
  .takeover_c(takeover_c));
`default_nettype wire

// *** gpio_pin_model.sv ***
// port pin that a compare output may take over
// assumes software drives the direction bit and the port level
`timescale 1ns/10ps
`default_nettype none

module gpio_pin_model (
  input  wire logic compare_out,
  input  wire logic takeover,
  input  wire logic dir_out,
  input  wire logic port_out,
  output var  logic pin
);
  // ----------------------------------------------------------------
  // pin mux
  // ----------------------------------------------------------------
  // a pin without its direction bit floats to the pull-up
  always_comb begin
    if (!dir_out)
      pin = 1'b1;
    else if (takeover)
      pin = compare_out;
    else
      pin = port_out;
  end
endmodule // gpio_pin_model
`default_nettype wire

// *** test_timer_wave.sv ***
// self-checking bench for the two-timer waveform block
// assumes the monitor is bound to the block and a pin model on timer1 a
`timescale 1ns/10ps
`default_nettype none

module test_timer_wave;
  logic       ref_clk;
  logic       nrst;
  logic       clk_en;
  logic       timer_tick;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  wire  [7:0] rdata;
  wire  [1:0] compare_pin_a;
  wire  [1:0] compare_pin_b;
  wire  [1:0] compare_pin_c;
  wire  [1:0] takeover_a;
  wire  [1:0] takeover_b;
  wire  [1:0] takeover_c;
  logic       dir_out;
  logic       port_out;
  logic       pin;
  int         num_errors;
  int         checked;
  wire  [2:0] pins_t1 = {compare_pin_a[0], compare_pin_b[0], compare_pin_c[0]};

  timer_wave dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .timer_tick(timer_tick),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .compare_pin_a(compare_pin_a), .compare_pin_b(compare_pin_b),
    .compare_pin_c(compare_pin_c), .takeover_a(takeover_a), .takeover_b(takeover_b),
    .takeover_c(takeover_c));
  gpio_pin_model gpio (.compare_out(compare_pin_a[0]), .takeover(takeover_a[0]),
    .dir_out(dir_out), .port_out(port_out), .pin(pin));

  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // bus, tick and compare tasks
  // ----------------------------------------------------------------
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one strobe cycle with no idle edge after it
  task wrq(input logic [4:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  // the extra edges let registered takeover outputs settle
  task wr(input logic [4:0] a, input logic [7:0] d);
    wrq(a, d);
    repeat (2) @(posedge ref_clk);
  endtask
  task rdc(input string name, input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
    chk(name, {8'h00, exp}, {8'h00, d});
    @(posedge ref_clk);
  endtask
  task tick(input int n);
    for (int i = 0; i < n; i++) begin
      timer_tick <= 1'b1;
      @(posedge ref_clk);
      timer_tick <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task do_reset;
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
  endtask
  task results;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task test_regs;
    do_reset();
    rdc("ctrl1", 5'h00, 8'h00);
    rdc("ctrl3", 5'h10, 8'h00);
    rdc("ctrl3 second", 5'h11, 8'h00);
    wr(5'h0d, 8'hff);
    rdc("unmapped", 5'h0d, 8'h00);
    for (int ch = 0; ch < 3; ch++) begin
      wr(5'h00, 8'(ch + 1) << (6 - 2 * ch));
      chk("take t1", 16'h1 << (2 * ch), {takeover_c, takeover_b, takeover_a});
    end
    wrq(5'h10, 8'h9c);
    rdc("ctrl3 b2b", 5'h10, 8'h9c);
    wr(5'h10, 8'hfc);
    rdc("ctrl3 rb", 5'h10, 8'hfc);
    chk("take t3", 16'h3a, {takeover_c, takeover_b, takeover_a});
    chk("port pin", 16'h1, pin);
    wr(5'h00, 8'h80);
    chk("owned pin", 16'h0, pin);
    dir_out <= 1'b0;
    @(posedge ref_clk);
    chk("undriven pin", 16'h1, pin);
    dir_out <= 1'b1;
    $display("test_regs done");
  endtask
  task test_normal;
    do_reset();
    wr(5'h02, 8'h02);
    wr(5'h04, 8'h01);
    wr(5'h06, 8'h01);
    wr(5'h00, 8'h78);
    tick(2);
    chk("pins n2", 16'h2, pins_t1);
    tick(1);
    chk("pins n3", 16'h6, pins_t1);
    rdc("count", 5'h0a, 8'h03);
    wr(5'h0a, 8'h55);
    clk_en <= 1'b0;
    tick(1);
    clk_en <= 1'b1;
    rdc("count ro", 5'h0a, 8'h03);
    $display("test_normal done");
  endtask
  task test_fast;
    do_reset();
    wr(5'h02, 8'h10);
    wr(5'h04, 8'h10);
    wr(5'h06, 8'h10);
    wr(5'h01, 8'h08);
    wr(5'h00, 8'hb5);
    tick(256);
    chk("fast top", 16'h4, pins_t1);
    rdc("ovf top", 5'h0c, 8'h01);
    wr(5'h0c, 8'h01);
    rdc("ovf clr", 5'h0c, 8'h00);
    tick(16);
    chk("fast pre", 16'h4, pins_t1);
    tick(1);
    chk("fast match", 16'h2, pins_t1);
    $display("test_fast done");
  endtask
  task test_phase;
    do_reset();
    wr(5'h02, 8'h10);
    wr(5'h04, 8'h10);
    wr(5'h00, 8'he1);
    tick(17);
    chk("pc up", 16'h4, pins_t1);
    wr(5'h0c, 8'h01);
    tick(477);
    chk("pc pre", 16'h4, pins_t1);
    rdc("pc no ovf", 5'h0c, 8'h00);
    tick(1);
    chk("pc down", 16'h2, pins_t1);
    tick(16);
    rdc("pc ovf", 5'h0c, 8'h01);
    $display("test_phase done");
  endtask
  task test_dual;
    do_reset();
    wr(5'h02, 8'h04);
    wr(5'h06, 8'h04);
    wr(5'h01, 8'h10);
    wr(5'h00, 8'h79);
    tick(5);
    chk("dual hold", 16'h7, pins_t1);
    wr(5'h0c, 8'h01);
    tick(3);
    rdc("pfc no ovf", 5'h0c, 8'h00);
    tick(1);
    rdc("pfc ovf", 5'h0c, 8'h01);
    tick(4);
    chk("dual toggle", 16'h3, pins_t1);
    $display("test_dual done");
  endtask
  task test_ctc;
    do_reset();
    wr(5'h02, 8'h03);
    wr(5'h01, 8'h08);
    wr(5'h00, 8'h40);
    tick(4);
    chk("ctc toggle", 16'h1, compare_pin_a[0]);
    rdc("ctc count", 5'h0a, 8'h00);
    tick(4);
    chk("ctc again", 16'h0, compare_pin_a[0]);
    $display("test_ctc done");
  endtask

  initial begin
    #500000;
    num_errors++;
    results();
  end
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    timer_tick = 1'b0;
    addr = 5'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    dir_out = 1'b1;
    port_out = 1'b1;
    num_errors = 0;
    checked = 0;
    @(posedge ref_clk);
    test_regs();
    test_normal();
    test_fast();
    test_phase();
    test_dual();
    test_ctc();
    results();
  end
endmodule // test_timer_wave
`default_nettype wire
